// file: verilog/fieldbus_io_register_map.sv
// Register map of the I/O coupler as seen from the fieldbus master
//
// Summary of operation
// - Coils read 1, written 5 or 15
// - Coils also packed in holding word, code 3
// - Discrete inputs read bitwise with code 2
// - Inputs packed in word, codes 4 and 3
// - Analog channels reached only by word codes
// - Analog input: status word, then data word
// - Analog output: control word, then data word
// - Analog output control word has no effect
// - Unused upper bytes pad to word boundary
// - Output data written with code 6 or 16
// - Analog input words readable with codes 4 or 3, output words with code 3 only
// - Status shows fault, over or under range
// - Status bit 0 under, 1 over, 6 error
// - Status bits readable by word only, not per bit
// - Serial variant: one data word per channel
// - Ethernet variant: four words per channel
// - Channels allocated in order, status first
`timescale 1ns/1ns
`default_nettype none

module fieldbus_io_register_map
(
   input  wire logic                      CLK_I,
   input  wire logic                      RSTN_I,
   input  wire logic                      MAP_SERIAL_I,
   input  wire fieldbus_io_pkg::req_t     REQ_I,
   output fieldbus_io_pkg::rsp_t          RSP_O,
   input  wire logic [7:0]                DI_I,
   input  wire fieldbus_io_pkg::ai_bank_t AI_I,
   output logic [7:0]                     DO_O,
   output fieldbus_io_pkg::ao_bank_t      AO_O
);
   import fieldbus_io_pkg::*;

   // Channel select for one analog block; used for inputs and outputs
   function automatic ana_sel_t ana_decode
   (
      input logic [15:0] addr,
      input logic [15:0] base,
      input logic        serial
   );
      logic [15:0] off;
      ana_sel_t    sel;
      off = addr - base;
      if (serial)
      begin
         sel.hit  = off < 16'(NUM_AI);
         sel.ch   = off[1:0];
         sel.slot = SLOT_DATA;
      end
      else
      begin
         sel.hit  = off < 16'(NUM_AI * WORDS_ETH);
         sel.ch   = off[3:2];
         sel.slot = off[1:0];
      end
      return sel;
   endfunction

   logic              serial_meta_q;
   logic              serial_q;
   logic [NUM_DI-1:0] di_meta_q;
   logic [NUM_DI-1:0] di_q;
   ai_bank_t          ai_meta_q;
   ai_bank_t          ai_q;
   logic [NUM_DO-1:0] do_q;
   ao_bank_t          ao_q;
   rsp_t              rsp_q;
   rsp_t              rsp_d;
   req_t              last_q;

   ana_sel_t          ai_s;
   ana_sel_t          ao_s;
   logic              in_hit;
   logic [15:0]       in_word;
   logic [15:0]       ai_word;
   logic [15:0]       ao_word;
   logic              do_we;
   logic              do_val;
   logic              ao_we;

   // Strap, inputs and channel data come from terminal logic outside this clock
   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         serial_meta_q <= 1'b0;
         serial_q      <= 1'b0;
      end
      else
      begin
         serial_meta_q <= MAP_SERIAL_I;
         serial_q      <= serial_meta_q;
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         di_meta_q <= '0;
         di_q      <= '0;
         ai_meta_q <= '0;
         ai_q      <= '0;
      end
      else
      begin
         di_meta_q <= DI_I;
         di_q      <= di_meta_q;
         ai_meta_q <= AI_I;
         ai_q      <= ai_meta_q;
      end
   end

   assign ai_s = ana_decode(REQ_I.addr, AI_BASE, serial_q);
   assign ao_s = ana_decode(REQ_I.addr, AO_BASE, serial_q);

   // Status byte in the low half; the upper byte is padding and reads zero
   always_comb
   begin
      ai_word = '0;
      unique case (ai_s.slot)
         SLOT_STAT:
         begin
            ai_word[ST_UNDER_BIT] = ai_q[ai_s.ch].under;
            ai_word[ST_OVER_BIT]  = ai_q[ai_s.ch].over;
            ai_word[ST_ERR_BIT]   = ai_q[ai_s.ch].fault |
                                    ai_q[ai_s.ch].over |
                                    ai_q[ai_s.ch].under;
         end
         SLOT_DATA: ai_word = ai_q[ai_s.ch].value;
         default:   ai_word = '0;
      endcase
   end

   // Control word is not stored, so it always reads zero
   always_comb
   begin
      ao_word = '0;
      if (ao_s.slot == SLOT_DATA)
      begin
         ao_word = ao_q[ao_s.ch];
      end
   end

   // Words common to input and holding register reads
   always_comb
   begin
      in_hit  = 1'b1;
      in_word = '0;
      if (REQ_I.addr == DI_WORD_ADDR)
      begin
         in_word = {8'h00, di_q};
      end
      else if (ai_s.hit)
      begin
         in_word = ai_word;
      end
      else
      begin
         in_hit = 1'b0;
      end
   end

   always_comb
   begin
      rsp_d       = '0;
      rsp_d.valid = REQ_I.valid;
      rsp_d.exc   = EXC_NONE;
      do_we       = 1'b0;
      do_val      = 1'b0;
      ao_we       = 1'b0;
      unique case (REQ_I.fc)
         FC_RD_COILS:
         begin
            if (REQ_I.addr < 16'(NUM_DO))
               rsp_d.data = {15'h0000, do_q[REQ_I.addr[2:0]]};
            else
               rsp_d.exc = EXC_ADDR;
         end
         FC_RD_DISC:
         begin
            if (REQ_I.addr < 16'(NUM_DI))
               rsp_d.data = {15'h0000, di_q[REQ_I.addr[2:0]]};
            else
               rsp_d.exc = EXC_ADDR;
         end
         FC_RD_INPUT:
         begin
            if (in_hit)
               rsp_d.data = in_word;
            else
               rsp_d.exc = EXC_ADDR;
         end
         FC_RD_HOLD:
         begin
            if (in_hit)
               rsp_d.data = in_word;
            else if (REQ_I.addr == DO_WORD_ADDR)
               rsp_d.data = {8'h00, do_q};
            else if (ao_s.hit)
               rsp_d.data = ao_word;
            else
               rsp_d.exc = EXC_ADDR;
         end
         FC_WR_COIL:
         begin
            if (REQ_I.addr >= 16'(NUM_DO))
               rsp_d.exc = EXC_ADDR;
            else if (REQ_I.wdata == COIL_ON || REQ_I.wdata == COIL_OFF)
            begin
               do_we  = REQ_I.valid;
               do_val = REQ_I.wdata == COIL_ON;
            end
            else
               rsp_d.exc = EXC_VALUE;
         end
         FC_WR_COILS:
         begin
            if (REQ_I.addr < 16'(NUM_DO))
            begin
               do_we  = REQ_I.valid;
               do_val = REQ_I.wdata[0];
            end
            else
               rsp_d.exc = EXC_ADDR;
         end
         FC_WR_REG, FC_WR_REGS:
         begin
            // Control and padding words accept the write and drop it
            if (ao_s.hit)
               ao_we = REQ_I.valid && ao_s.slot == SLOT_DATA;
            else
               rsp_d.exc = EXC_ADDR;
         end
         default: rsp_d.exc = EXC_FUNC;
      endcase
      if (!REQ_I.valid)
      begin
         rsp_d = '0;
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         do_q <= DO_RESET;
      else if (do_we)
         do_q[REQ_I.addr[2:0]] <= do_val;
   end

   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         ao_q <= {NUM_AO{AO_RESET}};
      else if (ao_we)
         ao_q[ao_s.ch] <= REQ_I.wdata;
   end

   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         rsp_q <= '0;
      else
         rsp_q <= rsp_d;
   end

   // Copy of the request, read only by the checks below
   always_ff @(posedge CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         last_q <= '0;
      else
         last_q <= REQ_I;
   end

   assign RSP_O = rsp_q;
   assign DO_O  = do_q;
   assign AO_O  = ao_q;

   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);

   a_coil_set:
   assert property (REQ_I.valid && REQ_I.fc == FC_WR_COIL && REQ_I.addr < 16'(NUM_DO)
                    && REQ_I.wdata == COIL_ON
                    |=> DO_O[last_q.addr[2:0]] && RSP_O.exc == EXC_NONE)
   else $error("coil write did not set the output");

   a_do_packed:
   assert property (REQ_I.valid && REQ_I.fc == FC_RD_HOLD && REQ_I.addr == DO_WORD_ADDR
                    |=> RSP_O.valid && RSP_O.data == {8'h00, $past(DO_O)})
   else $error("packed coil word wrong");

   a_di_bit:
   assert property (REQ_I.valid && REQ_I.fc == FC_RD_DISC && REQ_I.addr < 16'(NUM_DI)
                    |=> RSP_O.data[0] == $past(di_q[REQ_I.addr[2:0]]) && RSP_O.data[15:1] == 15'h0000)
   else $error("discrete input bit wrong");

   a_di_word:
   assert property (REQ_I.valid && (REQ_I.fc == FC_RD_INPUT || REQ_I.fc == FC_RD_HOLD)
                    && REQ_I.addr == DI_WORD_ADDR
                    |=> RSP_O.data == {8'h00, $past(di_q)} && RSP_O.exc == EXC_NONE)
   else $error("packed input word wrong");

   a_bit_range:
   assert property (REQ_I.valid && (REQ_I.fc == FC_RD_COILS || REQ_I.fc == FC_WR_COILS)
                    && REQ_I.addr >= AI_BASE
                    |=> RSP_O.exc == EXC_ADDR && $stable(DO_O) && $stable(AO_O))
   else $error("bit access reached analog space");

   a_ctrl_ignored:
   assert property (REQ_I.valid && REQ_I.fc == FC_WR_REG && !serial_q
                    && REQ_I.addr == AO_BASE
                    |=> $stable(AO_O) && RSP_O.exc == EXC_NONE)
   else $error("control word changed an output");

   a_ao_write:
   assert property (REQ_I.valid && REQ_I.fc == FC_WR_REGS && !serial_q
                    && REQ_I.addr == AO_BASE + 16'h0001
                    |=> AO_O[0] == last_q.wdata && RSP_O.valid && RSP_O.exc == EXC_NONE)
   else $error("output data word not written");

   a_status_bits:
   assert property (REQ_I.valid && REQ_I.fc == FC_RD_INPUT && !serial_q
                    && REQ_I.addr == AI_BASE
                    |=> RSP_O.data[ST_UNDER_BIT] == $past(ai_q[0].under)
                        && RSP_O.data[ST_OVER_BIT] == $past(ai_q[0].over)
                        && RSP_O.data[ST_ERR_BIT] == $past(ai_q[0].fault | ai_q[0].over | ai_q[0].under)
                        && RSP_O.data[15:8] == 8'h00)
   else $error("status bits misplaced");

   a_serial_data:
   assert property (REQ_I.valid && REQ_I.fc == FC_RD_INPUT && serial_q
                    && REQ_I.addr == AI_BASE + 16'h0001
                    |=> RSP_O.data == $past(ai_q[1].value))
   else $error("serial channel not one word");

   a_bad_func:
   assert property (REQ_I.valid && REQ_I.fc == 8'h07
                    |=> RSP_O.valid && RSP_O.exc == EXC_FUNC && $stable(DO_O) && $stable(AO_O))
   else $error("illegal code not refused");

   c_coil_write:  cover property (REQ_I.valid && REQ_I.fc == FC_WR_COIL ##1 RSP_O.valid);
   c_ao_write:    cover property (ao_we ##1 RSP_O.exc == EXC_NONE);
   c_status_err:  cover property (RSP_O.valid && RSP_O.data[ST_ERR_BIT] && last_q.fc == FC_RD_HOLD);
   c_exception:   cover property (RSP_O.valid && RSP_O.exc != EXC_NONE);

endmodule

`default_nettype wire

// file: verilog/fieldbus_io_pkg.sv
// Package: address map, function codes and carriers of the fieldbus I/O register map
package fieldbus_io_pkg;

   // Point and channel counts of the assembled terminals
   localparam int          NUM_DO       = 8;
   localparam int          NUM_DI       = 8;
   localparam int          NUM_AI       = 4;
   localparam int          NUM_AO       = 4;
   localparam int          WORDS_ETH    = 4;

   // Zero-based register addresses
   localparam logic [15:0] DI_WORD_ADDR = 16'h0008;
   localparam logic [15:0] AI_BASE      = 16'h0010;
   localparam logic [15:0] AO_BASE      = 16'h0800;
   localparam logic [15:0] DO_WORD_ADDR = 16'h0830;

   // Word slots inside one analog channel
   localparam logic [1:0]  SLOT_STAT    = 2'h0;
   localparam logic [1:0]  SLOT_DATA    = 2'h1;

   // Analog input status word bit positions
   localparam int          ST_UNDER_BIT = 0;
   localparam int          ST_OVER_BIT  = 1;
   localparam int          ST_ERR_BIT   = 6;

   // Function codes
   localparam logic [7:0]  FC_RD_COILS  = 8'h01;
   localparam logic [7:0]  FC_RD_DISC   = 8'h02;
   localparam logic [7:0]  FC_RD_HOLD   = 8'h03;
   localparam logic [7:0]  FC_RD_INPUT  = 8'h04;
   localparam logic [7:0]  FC_WR_COIL   = 8'h05;
   localparam logic [7:0]  FC_WR_REG    = 8'h06;
   localparam logic [7:0]  FC_WR_COILS  = 8'h0F;
   localparam logic [7:0]  FC_WR_REGS   = 8'h10;

   // Exception codes
   localparam logic [7:0]  EXC_NONE     = 8'h00;
   localparam logic [7:0]  EXC_FUNC     = 8'h01;
   localparam logic [7:0]  EXC_ADDR     = 8'h02;
   localparam logic [7:0]  EXC_VALUE    = 8'h03;

   // Single coil write values
   localparam logic [15:0] COIL_ON      = 16'hFF00;
   localparam logic [15:0] COIL_OFF     = 16'h0000;

   // Values after reset
   localparam logic [NUM_DO-1:0] DO_RESET = 8'h00;
   localparam logic [15:0]       AO_RESET = 16'h0000;

   typedef struct packed {
      logic        valid;
      logic [7:0]  fc;
      logic [15:0] addr;
      logic [15:0] wdata;
   } req_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  exc;
      logic [15:0] data;
   } rsp_t;

   typedef struct packed {
      logic        fault;
      logic        over;
      logic        under;
      logic [15:0] value;
   } ai_chan_t;

   typedef struct packed {
      logic       hit;
      logic [1:0] ch;
      logic [1:0] slot;
   } ana_sel_t;

   typedef ai_chan_t [NUM_AI-1:0]    ai_bank_t;
   typedef logic [NUM_AO-1:0][15:0] ao_bank_t;

endpackage

// file: test/modbus_master_model.sv
// Bus master model issuing one register or bit item per clock
`timescale 1ns/1ns
`default_nettype none

module modbus_master_model
(
   input  wire logic                 clk_i,
   output var fieldbus_io_pkg::req_t req_o
);
   import fieldbus_io_pkg::*;

   initial req_o = '0;

   // Items change at the falling edge so the sampling edge always sees them settled
   task automatic issue(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w);
      @(negedge clk_i);
      req_o = '{1'b1, f, a, w};
   endtask

   task automatic idle();
      @(negedge clk_i);
      req_o = '0;
   endtask
endmodule

`default_nettype wire

// file: test/tb.sv
// Self-checking bench of the fieldbus register map driven by a bus master model
`timescale 1ns/1ns
`default_nettype none

module tb;
   import fieldbus_io_pkg::*;

   logic        clk;
   logic        rst_n;
   logic        serial;
   logic [7:0]  di;
   ai_bank_t    ai;
   req_t        req;
   rsp_t        rsp;
   logic [7:0]  do_w;
   ao_bank_t    ao_w;
   logic [7:0]  do_m;
   ao_bank_t    ao_m;
   logic [15:0] rnd;
   logic [23:0] exp_r;
   logic [23:0] expq [$];
   logic [7:0]  bad_fc [4] = '{8'h00, 8'h07, 8'h11, 8'h2B};
   int          n_errors;
   int          samples_checked;

   fieldbus_io_register_map fieldbus_io_register_map_i
   (
      .CLK_I        (clk),
      .RSTN_I       (rst_n),
      .MAP_SERIAL_I (serial),
      .REQ_I        (req),
      .RSP_O        (rsp),
      .DI_I         (di),
      .AI_I         (ai),
      .DO_O         (do_w),
      .AO_O         (ao_w)
   );

   modbus_master_model modbus_master_model_i
   (
      .clk_i (clk),
      .req_o (req)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Reference map; updates the expected outputs as a side effect
   function automatic logic [23:0] model(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w);
      logic [15:0] oi;
      logic [15:0] oo;
      logic        ok_i;
      logic        ok_o;
      logic [1:0]  ci;
      logic [1:0]  co;
      logic        st_e;
      oi = a - AI_BASE;
      oo = a - AO_BASE;
      ok_i = a >= AI_BASE && oi < (serial ? 16'h0004 : 16'h0010);
      ok_o = a >= AO_BASE && oo < (serial ? 16'h0004 : 16'h0010);
      ci = serial ? oi[1:0] : oi[3:2];
      co = serial ? oo[1:0] : oo[3:2];
      st_e = ai[ci].fault | ai[ci].over | ai[ci].under;
      case (f)
         FC_RD_COILS: if (a < 16'h0008) return {EXC_NONE, 15'h0, do_m[a[2:0]]};
         FC_RD_DISC: if (a < 16'h0008) return {EXC_NONE, 15'h0, di[a[2:0]]};
         FC_WR_COIL: if (a < 16'h0008)
         begin
            if (w != COIL_ON && w != COIL_OFF)
               return {EXC_VALUE, 16'h0};
            do_m[a[2:0]] = w[15];
            return 24'h0;
         end
         FC_WR_COILS: if (a < 16'h0008)
         begin
            do_m[a[2:0]] = w[0];
            return 24'h0;
         end
         FC_RD_HOLD, FC_RD_INPUT:
         begin
            if (a == DI_WORD_ADDR)
               return {EXC_NONE, 8'h00, di};
            if (ok_i && !serial && oi[1:0] == SLOT_STAT)
               return {EXC_NONE, 9'h0, st_e, 4'h0, ai[ci].over, ai[ci].under};
            if (ok_i)
               return (serial || oi[1:0] == SLOT_DATA) ? {EXC_NONE, ai[ci].value} : 24'h0;
            if (f == FC_RD_HOLD && a == DO_WORD_ADDR)
               return {EXC_NONE, 8'h00, do_m};
            if (f == FC_RD_HOLD && ok_o)
               return (serial || oo[1:0] == SLOT_DATA) ? {EXC_NONE, ao_m[co]} : 24'h0;
         end
         FC_WR_REG, FC_WR_REGS: if (ok_o)
         begin
            if (serial || oo[1:0] == SLOT_DATA)
               ao_m[co] = w;
            return 24'h0;
         end
         default: return {EXC_FUNC, 16'h0};
      endcase
      return {EXC_ADDR, 16'h0};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w);
      expq.push_back(model(f, a, w));
      modbus_master_model_i.issue(f, a, w);
   endtask

   task automatic settle(input int n);
      modbus_master_model_i.idle();
      repeat (n) @(negedge clk);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      #(40 * 4000);
      n_errors++;
      complete_run();
   end

   // A missing note means an answer came that no request asked for
   always @(posedge clk)
   begin
      #1;
      if (rsp.valid === 1'b1)
      begin
         exp_r = expq.size() > 0 ? expq.pop_front() : 24'hFFFFFF;
         check({8'h00, rsp.exc}, {8'h00, exp_r[23:16]});
         if (exp_r[23:16] === EXC_NONE)
            check(rsp.data, exp_r[15:0]);
      end
   end

   initial
   begin
      rst_n = 1'b0;
      serial = 1'b0;
      di = 8'h00;
      ai = '0;
      do_m = DO_RESET;
      ao_m = '0;
      rnd = 16'h0038;
      n_errors = 0;
      samples_checked = 0;
      repeat (5) @(negedge clk);
      check({8'h00, do_w}, {8'h00, DO_RESET});
      check({15'h0, rsp.valid}, 16'h0000);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         xfer(FC_WR_COIL, 16'(i), rnd[0] ? COIL_ON : COIL_OFF);
         xfer(FC_RD_COILS, 16'(i), rnd);
      end
      xfer(FC_RD_HOLD, DO_WORD_ADDR, rnd);
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         xfer(FC_WR_COILS, 16'(i), rnd);
      end
      xfer(FC_RD_HOLD, DO_WORD_ADDR, rnd);
      xfer(FC_WR_COIL, 16'h0002, 16'h1234);
      xfer(FC_RD_COILS, 16'h0008, rnd);
      xfer(FC_WR_REG, DO_WORD_ADDR, rnd);
      xfer(FC_RD_INPUT, DO_WORD_ADDR, rnd);
      xfer(FC_WR_COIL, AI_BASE, COIL_ON);
      xfer(FC_RD_COILS, AO_BASE, rnd);
      xfer(FC_RD_DISC, AI_BASE, rnd);
      foreach (bad_fc[k])
         xfer(bad_fc[k], 16'h0000, rnd);
      settle(0);
      check({8'h00, do_w}, {8'h00, do_m});
      for (int r = 0; r < 3; r++)
      begin
         rnd = lfsr(rnd);
         di = rnd[7:0];
         for (int c = 0; c < NUM_AI; c++)
         begin
            rnd = lfsr(rnd);
            ai[c] = {rnd[15:13], rnd};
         end
         // Inputs pass a two-flop synchroniser before they are visible
         repeat (3) @(negedge clk);
         for (int i = 0; i < 8; i++)
            xfer(FC_RD_DISC, 16'(i), rnd);
         xfer(FC_RD_INPUT, DI_WORD_ADDR, rnd);
         xfer(FC_RD_HOLD, DI_WORD_ADDR, rnd);
         for (int i = 0; i < 17; i++)
         begin
            xfer(FC_RD_INPUT, AI_BASE + 16'(i), rnd);
            xfer(FC_RD_HOLD, AI_BASE + 16'(i), rnd);
         end
         modbus_master_model_i.idle();
      end
      for (int i = 0; i < 16; i++)
      begin
         rnd = lfsr(rnd);
         xfer(i[0] ? FC_WR_REGS : FC_WR_REG, AO_BASE + 16'(i), rnd);
      end
      for (int i = 0; i < 17; i++)
         xfer(FC_RD_HOLD, AO_BASE + 16'(i), rnd);
      xfer(FC_RD_INPUT, AO_BASE + 16'h0001, rnd);
      xfer(FC_WR_COIL, AO_BASE, COIL_ON);
      settle(0);
      for (int c = 0; c < NUM_AO; c++)
         check(ao_w[c], ao_m[c]);
      serial = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 5; i++)
      begin
         rnd = lfsr(rnd);
         xfer(FC_WR_REG, AO_BASE + 16'(i), rnd);
         xfer(FC_RD_HOLD, AO_BASE + 16'(i), rnd);
         xfer(FC_RD_INPUT, AI_BASE + 16'(i), rnd);
      end
      settle(2);
      for (int c = 0; c < NUM_AO; c++)
         check(ao_w[c], ao_m[c]);
      check(16'(expq.size()), 16'h0000);
      complete_run();
   end
endmodule

`default_nettype wire
